// file: verilog/sink_frl_map.vh
// Purpose: Offsets, fields, resets and timing of the link training port
// Assumes: 40 MHz management clock
// Notes: Register offsets are byte addresses of 32-bit words
`ifndef SINK_FRL_MAP_VH
`define SINK_FRL_MAP_VH
`define CLK_KHZ 40000
`define HPD_DELAY_MS 1000
// One second of management clock, sized to the hot-plug counter
`define HPD_DELAY_CYC 26'd40000000
`define HPD_CNT_W 26
`define SPAN_3LANE 10'h2a8
`define SPAN_4LANE 10'h1fe
`define SPAN_W 10
`define LOCK_REPEAT 2'h3
`define LTP_FIXED 16'h5678
`define LTP_FFE_REQ 16'heeee
`define LTP_RATE_REQ 16'hffff
`define LTP_RESET 16'h0000
`define RATE_OFF 4'h0
`define RATE_MAX 4'h6
`define RATE_3L_LAST 4'h2
`define FLT_READY_BIT 6
`define SRC_CFG_MASK 8'hee
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_RATE 8'h04
`define REG_STATUS 8'h08
`define REG_FLAGS 8'h0c
`define REG_SRC_CFG 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_MASK 8'h18
`define CTRL_LTP_EN 0
`define CTRL_START_SET 1
`define CTRL_UPD_CLR 2
`define IRQ_W 5
`define IRQ_LOCK_UP 0
`define IRQ_LOCK_DOWN 1
`define IRQ_HPD 2
`define IRQ_FLT_READY 3
`define IRQ_LTP_CHG 4
`endif

// file: verilog/sink_frl_link_training_status.v
// Purpose: Fixed-rate link training control and status port of a sink
// Assumes: Lane marker strobes and training inputs are on ref_clk_i
// Notes: Register port reads back one cycle after the read strobe
// Behaviour
// [RULE_01] Mode output is 0 for DVI, 1 for HDMI.
// [RULE_02] Outside logic supplies four-bit max equalizer level, config bits 7:4.
// [RULE_03] Four-bit rate code: 0 off, 1-2 three lanes, 3-6 four lanes.
// [RULE_04] Four-bit vector, one lock flag per lane.
// [RULE_05] Three lanes: lock after marker plus 680 periods, thrice; lane 3 clear.
// [RULE_06] Four lanes: lock after marker plus 510 periods, three times.
// [RULE_07] Training request drives status flag bytes 0x41 and 0x42.
// [RULE_08] Request nibbles map lane by lane onto the two flag bytes.
// [RULE_09] Controller sets request to zero to let training pass.
// [RULE_10] Request input disabled by default; fixed 0x5678 requested then.
// [RULE_11] Equalizer change pattern 0xEEEE is never passed on.
// [RULE_12] No autonomous rate change; pattern 0xFFFF is never passed on.
// [RULE_13] Training ready sets flag 0x40 bit 6, clears start, sets update.
// [RULE_14] Source test config follows byte 0x35; bits 4 and 0 reserved.
// [RULE_15] Hot-plug status drives a dedicated output for the connector.
// [RULE_16] Hot-plug low after reset or without 5 V; high 1 s after 5 V.
// [RULE_17] All outputs on the management clock, inactive after reset; flags 0x41 and 0x42 reset to the fixed 0x5678 here.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "sink_frl_map.vh"
module sink_frl_link_training_status #(
    parameter [`HPD_CNT_W-1:0] HPD_DELAY_CYCLES = `HPD_DELAY_CYC
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire srst_i,
    // Register port
    input wire [`ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output wire irq_o,
    // Pins from outside the clock domain
    input wire power_5v_present_i,
    input wire hdmi_detect_i,
    // Lane character strobes
    input wire [3:0] char_valid_i,
    input wire [3:0] scrambler_reset_char_i,
    input wire [3:0] start_super_block_char_i,
    // Training control inputs
    input wire [3:0] transmit_equalizer_i,
    input wire [15:0] ltp_req_i,
    input wire flt_ready_i,
    input wire [7:0] src_test_config_i,
    // Status outputs
    output reg mode_o,
    output reg [3:0] frl_rate_o,
    output wire [3:0] frl_locked_o,
    output reg [7:0] status_flag_40_o,
    output reg [7:0] status_flag_41_o,
    output reg [7:0] status_flag_42_o,
    output reg frl_start_o,
    output reg flt_update_o,
    output reg hpd_o
);

    function four_lane;
        input [3:0] rate;
        begin
            four_lane = (rate > `RATE_3L_LAST);
        end
    endfunction

    function rejected_ltp;
        input [15:0] req;
        begin
            rejected_ltp = (req == `LTP_FFE_REQ) || (req == `LTP_RATE_REQ);
        end
    endfunction

    wire wr_ctrl = wr_i && (addr_i == `REG_CTRL);
    wire wr_rate = wr_i && (addr_i == `REG_RATE);
    wire wr_mask = wr_i && (addr_i == `REG_IRQ_MASK);
    wire rd_irq = rd_i && (addr_i == `REG_IRQ_STAT);

    // Two-stage synchronisers for the pin inputs
    reg pwr_s1_q;
    reg pwr_s2_q;
    reg mode_s1_q;
    reg mode_s2_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            pwr_s1_q <= power_5v_present_i;
            pwr_s2_q <= pwr_s1_q;
            mode_s1_q <= hdmi_detect_i;
            mode_s2_q <= mode_s1_q;
        end
    end

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            mode_o <= 1'b0;
        end else begin
            mode_o <= mode_s2_q; // see [RULE_01]
        end
    end

    // Hot-plug delay: restart the count whenever 5 V drops
    reg [`HPD_CNT_W-1:0] hpd_cnt_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            hpd_cnt_q <= {`HPD_CNT_W{1'b0}};
            hpd_o <= 1'b0;
        end else if (!pwr_s2_q) begin
            hpd_cnt_q <= {`HPD_CNT_W{1'b0}};
            hpd_o <= 1'b0; // see [RULE_16]
        end else if (hpd_cnt_q < HPD_DELAY_CYCLES - 1'b1) begin
            hpd_cnt_q <= hpd_cnt_q + 1'b1;
        end else begin
            hpd_o <= 1'b1; // see [RULE_15] see [RULE_16]
        end
    end

    // Control, rate and interrupt mask registers
    reg ltp_en_q;
    reg [`IRQ_W-1:0] irq_mask_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            ltp_en_q <= 1'b0; // see [RULE_10]
            frl_rate_o <= `RATE_OFF;
            irq_mask_q <= {`IRQ_W{1'b0}};
        end else begin
            if (wr_ctrl) begin
                ltp_en_q <= wdata_i[`CTRL_LTP_EN];
            end
            // Only software moves the rate; out-of-range codes are ignored
            if (wr_rate && (wdata_i[3:0] <= `RATE_MAX)) begin
                frl_rate_o <= wdata_i[3:0]; // see [RULE_03] see [RULE_12]
            end
            if (wr_mask) begin
                irq_mask_q <= wdata_i[`IRQ_W-1:0];
            end
        end
    end

    // Lane lock detection
    wire is_four = four_lane(frl_rate_o);
    wire [`SPAN_W-1:0] span = is_four ? `SPAN_4LANE : `SPAN_3LANE;
    wire rate_chg = wr_rate && (wdata_i[3:0] <= `RATE_MAX);
    wire [3:0] lock_q;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            reg [`SPAN_W-1:0] per_q;
            reg [1:0] hits_q;
            reg locked_q;
            wire marker = char_valid_i[g] &&
                (scrambler_reset_char_i[g] || start_super_block_char_i[g]);
            wire active = (frl_rate_o != `RATE_OFF) && (is_four || (g != 3));
            always @(posedge ref_clk_i) begin
                if (srst_i || rate_chg || !active) begin
                    per_q <= {`SPAN_W{1'b0}};
                    hits_q <= 2'h0;
                    locked_q <= 1'b0; // see [RULE_05] see [RULE_17]
                end else if (marker) begin
                    per_q <= {`SPAN_W{1'b0}};
                    // A marker at the wrong spacing restarts the count
                    if (per_q == span) begin
                        if (hits_q != `LOCK_REPEAT) begin
                            hits_q <= hits_q + 1'b1;
                        end
                        if (hits_q == `LOCK_REPEAT - 1'b1) begin
                            locked_q <= 1'b1; // see [RULE_05] see [RULE_06]
                        end
                    end else begin
                        hits_q <= 2'h0;
                        locked_q <= 1'b0;
                    end
                end else if (char_valid_i[g] && (per_q <= span)) begin
                    per_q <= per_q + 1'b1;
                end
            end
            assign lock_q[g] = locked_q;
        end
    endgenerate
    assign frl_locked_o = lock_q; // see [RULE_04]

    // Training pattern request
    localparam [15:0] LTP_FIXED_W = `LTP_FIXED;
    wire [15:0] ltp_sel = ltp_en_q ? ltp_req_i : `LTP_FIXED;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            status_flag_41_o <= LTP_FIXED_W[7:0];
            status_flag_42_o <= LTP_FIXED_W[15:8];
        end else if (!rejected_ltp(ltp_sel)) begin // see [RULE_11] see [RULE_12]
            // Zero passes straight through and ends training
            status_flag_42_o <= {ltp_sel[15:12], ltp_sel[11:8]}; // see [RULE_07] see [RULE_08]
            status_flag_41_o <= {ltp_sel[7:4], ltp_sel[3:0]}; // see [RULE_08] see [RULE_09]
        end
    end
    wire ltp_chg = !rejected_ltp(ltp_sel) &&
        ({status_flag_42_o, status_flag_41_o} != ltp_sel);

    // Training ready and update flags
    reg flt_ready_q;
    wire flt_rise = flt_ready_i && !flt_ready_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            flt_ready_q <= 1'b0;
            status_flag_40_o <= 8'h00;
            frl_start_o <= 1'b0;
            flt_update_o <= 1'b0;
        end else begin
            flt_ready_q <= flt_ready_i;
            status_flag_40_o[`FLT_READY_BIT] <= flt_ready_i; // see [RULE_13]
            if (flt_rise) begin
                frl_start_o <= 1'b0; // see [RULE_13]
            end else if (wr_ctrl && wdata_i[`CTRL_START_SET]) begin
                frl_start_o <= 1'b1;
            end
            // Setting wins over a clear in the same cycle
            if (flt_rise) begin
                flt_update_o <= 1'b1; // see [RULE_13]
            end else if (wr_ctrl && wdata_i[`CTRL_UPD_CLR]) begin
                flt_update_o <= 1'b0;
            end
        end
    end

    // Source configuration captured for software
    reg [3:0] ffe_q;
    reg [7:0] src_cfg_q;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            ffe_q <= 4'h0;
            src_cfg_q <= 8'h00;
        end else begin
            ffe_q <= transmit_equalizer_i; // see [RULE_02]
            src_cfg_q <= src_test_config_i & `SRC_CFG_MASK; // see [RULE_14]
        end
    end

    // Interrupt status, cleared by read; new events win over the clear
    reg [3:0] lock_prev_q;
    reg hpd_prev_q;
    reg [`IRQ_W-1:0] irq_stat_q;
    reg [`IRQ_W-1:0] irq_ev;
    always @* begin
        irq_ev = {`IRQ_W{1'b0}};
        irq_ev[`IRQ_LOCK_UP] = |(lock_q & ~lock_prev_q);
        irq_ev[`IRQ_LOCK_DOWN] = |(~lock_q & lock_prev_q);
        irq_ev[`IRQ_HPD] = hpd_o != hpd_prev_q;
        irq_ev[`IRQ_FLT_READY] = flt_rise;
        irq_ev[`IRQ_LTP_CHG] = ltp_chg;
    end
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            lock_prev_q <= 4'h0;
            hpd_prev_q <= 1'b0;
            irq_stat_q <= {`IRQ_W{1'b0}};
        end else begin
            lock_prev_q <= lock_q;
            hpd_prev_q <= hpd_o;
            irq_stat_q <= (rd_irq ? {`IRQ_W{1'b0}} : irq_stat_q) | irq_ev;
        end
    end
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // Read data, valid in the cycle after the strobe
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (addr_i)
            `REG_CTRL: rd_d[`CTRL_LTP_EN] = ltp_en_q;
            `REG_RATE: rd_d[3:0] = frl_rate_o;
            `REG_STATUS: rd_d[6:0] = {hpd_o, mode_o, pwr_s2_q, lock_q};
            `REG_FLAGS: rd_d[25:0] = {frl_start_o, flt_update_o,
                status_flag_42_o, status_flag_41_o, status_flag_40_o};
            `REG_SRC_CFG: rd_d[11:0] = {src_cfg_q, ffe_q};
            `REG_IRQ_STAT: rd_d[`IRQ_W-1:0] = irq_stat_q;
            `REG_IRQ_MASK: rd_d[`IRQ_W-1:0] = irq_mask_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= rd_d;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule // sink_frl_link_training_status

// file: tb/frl_port_monitor.sv
// Purpose: Port checker for the link training status block
// Assumes: Single management clock, synchronous active-high reset
// Notes: Hot-plug bounds allow a few edges of synchroniser slack
`timescale 1ns/10ps
module frl_port_monitor #(
    parameter [25:0] HPD_DELAY_CYCLES = 26'd40000000
) (
    // Clock, reset and bus
    input wire ref_clk_i,
    input wire srst_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    // Pins and controls
    input wire power_5v_present_i,
    input wire hdmi_detect_i,
    input wire [15:0] ltp_req_i,
    input wire flt_ready_i,
    // Status
    input wire mode_o,
    input wire [3:0] frl_rate_o,
    input wire [3:0] frl_locked_o,
    input wire [7:0] status_flag_40_o,
    input wire [7:0] status_flag_41_o,
    input wire [7:0] status_flag_42_o,
    input wire frl_start_o,
    input wire flt_update_o,
    input wire hpd_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    reg [25:0] pwr_cnt_q;
    // Saturates just past the delay so the counter never wraps in a long run
    always @(posedge ref_clk_i) begin
        if (srst_i || !power_5v_present_i)
            pwr_cnt_q <= 26'h0;
        else if (pwr_cnt_q < HPD_DELAY_CYCLES + 26'h8)
            pwr_cnt_q <= pwr_cnt_q + 26'h1;
    end
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside read slot");
    req_reject_a: assert property (
        (ltp_req_i == 16'heeee || ltp_req_i == 16'hffff) && !wr_i && !$past(wr_i)
        |=> $stable({status_flag_42_o, status_flag_41_o}))
        else $error("unsupported request pattern reached flags");
    flt_ready_a: assert property ($rose(flt_ready_i) && !wr_i
        |=> status_flag_40_o == 8'h40 && !frl_start_o && flt_update_o)
        else $error("training ready flags wrong");
    lane3_clear_a: assert property ((frl_rate_o == 4'h1 || frl_rate_o == 4'h2) |-> !frl_locked_o[3])
        else $error("lane 3 locked in three-lane mode");
    rate_off_a: assert property (frl_rate_o == 4'h0 |=> frl_locked_o == 4'h0)
        else $error("lock shown with link off");
    rate_range_a: assert property (frl_rate_o <= 4'h6)
        else $error("rate code out of range");
    mode_follow_a: assert property ($stable(hdmi_detect_i) [*3] ##0 !$past(srst_i, 3)
        |-> mode_o == hdmi_detect_i)
        else $error("mode does not follow detect pin");
    hpd_low_a: assert property (!power_5v_present_i [*4] |-> !hpd_o)
        else $error("hot-plug high without power");
    hpd_early_a: assert property ($rose(hpd_o) |-> pwr_cnt_q >= HPD_DELAY_CYCLES)
        else $error("hot-plug rose too early");
    hpd_late_a: assert property (pwr_cnt_q >= HPD_DELAY_CYCLES + 26'h4 |-> hpd_o)
        else $error("hot-plug late");
endmodule // frl_port_monitor
bind sink_frl_link_training_status frl_port_monitor #(.HPD_DELAY_CYCLES(HPD_DELAY_CYCLES)) frl_port_monitor_inst (
    .ref_clk_i, .srst_i, .wr_i, .rd_i, .rdata_o, .power_5v_present_i, .hdmi_detect_i, .ltp_req_i, .flt_ready_i,
    .mode_o, .frl_rate_o, .frl_locked_o, .status_flag_40_o, .status_flag_41_o, .status_flag_42_o,
    .frl_start_o, .flt_update_o, .hpd_o);

// file: tb/frl_source_model.sv
// Purpose: Source side of the lanes, sends four markers per burst
// Assumes: One character per clock on every lane
// Notes: Qualifiers toggle while idle so marker-like values show while valid is low
`timescale 1ns/10ps
module frl_source_model (
    input wire clk_i,
    input wire go_i,
    input wire [9:0] gap_i,
    output reg [3:0] valid_o,
    output reg [3:0] sr_o,
    output reg [3:0] ssb_o,
    output reg busy_o
);
    reg [9:0] sub_q;
    reg [2:0] marks_q;
    initial begin
        {valid_o, sr_o, ssb_o, busy_o, sub_q, marks_q} = 0;
    end
    always @(posedge clk_i) begin
        valid_o <= {4{busy_o}};
        // Marker then gap_i plain characters, alternating reset and super-block kinds
        if (busy_o && sub_q == 10'h0) begin
            sr_o <= {4{~marks_q[0]}};
            ssb_o <= {4{marks_q[0]}};
            marks_q <= marks_q + 3'h1;
        end else if (busy_o) begin
            {sr_o, ssb_o} <= 8'h0;
        end else begin
            {sr_o, ssb_o} <= ~{sr_o, ssb_o};
        end
        sub_q <= (!busy_o || sub_q == gap_i) ? 10'h0 : sub_q + 10'h1;
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            marks_q <= 3'h0;
        end else if (busy_o && sub_q == 10'h0 && marks_q == 3'h3)
            busy_o <= 1'b0;
    end
endmodule // frl_source_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the link training status block
// Assumes: Hot-plug delay shortened to 20 cycles
// Notes: Bus tasks drive right after the rising edge
`timescale 1ns/10ps
module tb;
    reg ref_clk_i, srst_i, wr_i, rd_i, power_5v_present_i, hdmi_detect_i, flt_ready_i, go;
    reg [7:0] addr_i, src_test_config_i;
    reg [31:0] wdata_i, v;
    reg [3:0] transmit_equalizer_i;
    reg [15:0] ltp_req_i;
    reg [9:0] gap;
    wire [31:0] rdata_o;
    wire irq_o, mode_o, frl_start_o, flt_update_o, hpd_o, busy;
    wire [3:0] frl_rate_o, frl_locked_o, cv, sr, start_super_block_char;
    wire [7:0] f40, f41, f42;
    integer mismatches, n_checks, i, n;
    sink_frl_link_training_status #(.HPD_DELAY_CYCLES(26'd20)) sink_frl_link_training_status_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .power_5v_present_i(power_5v_present_i), .hdmi_detect_i(hdmi_detect_i),
        .char_valid_i(cv), .scrambler_reset_char_i(sr), .start_super_block_char_i(start_super_block_char),
        .transmit_equalizer_i(transmit_equalizer_i), .ltp_req_i(ltp_req_i), .flt_ready_i(flt_ready_i),
        .src_test_config_i(src_test_config_i), .mode_o(mode_o), .frl_rate_o(frl_rate_o), .frl_locked_o(frl_locked_o),
        .status_flag_40_o(f40), .status_flag_41_o(f41), .status_flag_42_o(f42), .frl_start_o(frl_start_o),
        .flt_update_o(flt_update_o), .hpd_o(hpd_o));
    frl_source_model frl_source_model_inst (.clk_i(ref_clk_i), .go_i(go), .gap_i(gap), .valid_o(cv), .sr_o(sr),
        .ssb_o(start_super_block_char), .busy_o(busy));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task cyc(input integer k);
        begin
            repeat (k) @(posedge ref_clk_i);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge ref_clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge ref_clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge ref_clk_i);
            rd_i <= 1'b0;
            #1 v = rdata_o;
        end
    endtask
    task req_chk(input [15:0] r, input [15:0] e);
        begin
            @(posedge ref_clk_i);
            ltp_req_i <= r;
            cyc(2);
            chk({16'h0, f42, f41}, {16'h0, e});
        end
    endtask
    initial begin
        {wr_i, rd_i, power_5v_present_i, hdmi_detect_i, flt_ready_i, go, addr_i, wdata_i} = 0;
        {srst_i, mismatches, n_checks, gap} = {1'b1, 64'h0, 10'h0};
        transmit_equalizer_i = 4'h9;
        src_test_config_i = 8'hff;
        ltp_req_i = 16'h1234;
        repeat (20) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        cyc(2);
        chk({hpd_o, mode_o, frl_start_o, flt_update_o, frl_locked_o, frl_rate_o, f40}, 24'h0);
        chk({f42, f41}, 16'h5678);
        rd(8'h1c);
        chk(v, 32'h0);
        rd(8'h10);
        chk(v, 32'hee9);
        wr(8'h04, 32'h7);
        cyc(1);
        chk(frl_rate_o, 4'h0);
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h04, (i == 2) ? 32'h1 : 32'h3);
            @(posedge ref_clk_i);
            gap <= (i == 0) ? 10'd510 : (i == 1) ? 10'd509 : 10'd680;
            go <= 1'b1;
            @(posedge ref_clk_i);
            go <= 1'b0;
            // The source raises busy on this same edge, so poll from the next one
            cyc(1);
            for (n = 0; busy && n < 3000; n = n + 1)
                cyc(1);
            if (n == 3000) begin
                chk(32'h0, 32'h1);
                report_and_stop;
            end
            cyc(3);
            chk(frl_locked_o, (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'h7);
        end
        rd(8'h04);
        chk(v, 32'h1);
        rd(8'h08);
        chk(v, 32'h7);
        wr(8'h04, 32'h0);
        cyc(1);
        chk(frl_locked_o, 4'h0);
        wr(8'h00, 32'h1);
        req_chk(16'h1234, 16'h1234);
        req_chk(16'heeee, 16'h1234);
        req_chk(16'hffff, 16'h1234);
        req_chk(16'h0000, 16'h0000);
        for (i = 1; i >= 0; i = i - 1) begin
            @(posedge ref_clk_i);
            hdmi_detect_i <= i[0];
            cyc(4);
            chk(mode_o, i[0]);
        end
        wr(8'h18, 32'h8);
        rd(8'h14);
        wr(8'h00, 32'h3);
        cyc(1);
        chk(frl_start_o, 1'b1);
        @(posedge ref_clk_i);
        flt_ready_i <= 1'b1;
        cyc(2);
        chk({f40, frl_start_o, flt_update_o, irq_o}, 11'h203);
        rd(8'h14);
        chk(v & 32'h8, 32'h8);
        rd(8'h0c);
        chk(v, 32'h0100_0040);
        cyc(1);
        chk(irq_o, 1'b0);
        wr(8'h00, 32'h5);
        wr(8'h18, 32'h0);
        cyc(1);
        chk(flt_update_o, 1'b0);
        @(posedge ref_clk_i);
        flt_ready_i <= 1'b0;
        cyc(2);
        @(posedge ref_clk_i);
        flt_ready_i <= 1'b1;
        cyc(3);
        chk(irq_o, 1'b0);
        rd(8'h14);
        chk(v & 32'h8, 32'h8);
        @(posedge ref_clk_i);
        power_5v_present_i <= 1'b1;
        cyc(10);
        chk(hpd_o, 1'b0);
        cyc(20);
        chk(hpd_o, 1'b1);
        @(posedge ref_clk_i);
        power_5v_present_i <= 1'b0;
        cyc(4);
        chk(hpd_o, 1'b0);
        report_and_stop;
    end
endmodule // tb
